// File: rtl/smpsc_pkg.sv
package smpsc_pkg;

  // Register offsets, word addressed by index
  localparam logic [3:0] OFS_LEVEL   = 4'h0;
  localparam logic [3:0] OFS_CLOCK   = 4'h1;
  localparam logic [3:0] OFS_BYPASS  = 4'h2;
  localparam logic [3:0] OFS_REG     = 4'h3;
  localparam logic [3:0] OFS_STATUS  = 4'h4;
  localparam logic [3:0] OFS_VOUT    = 4'h5;

  // Field positions
  localparam int CLK_FIX8_BIT   = 0;
  localparam int CLK_VAR_EN_BIT = 1;
  localparam int CLK_DIV_LSB    = 4;
  localparam int CLK_CDF_LSB    = 8;
  localparam int REG_LP_HI_BIT  = 0;
  localparam int REG_FORCE_BIT  = 1;
  localparam int REG_STOP_BIT   = 2;

  // Reset values and divider limits
  localparam logic [3:0] LEVEL_RST    = 4'h0;
  localparam logic [4:0] DIV_RST      = 5'h08;
  localparam logic [4:0] DIV_MIN      = 5'h08;
  localparam logic [4:0] DIV_MAX      = 5'h10;

  // Output voltage limits in units of 100 mV, and first level code above the minimum
  localparam logic [4:0] VOUT_MIN     = 5'h0c;
  localparam logic [4:0] VOUT_MAX     = 5'h18;
  localparam logic [3:0] CODE_FIRST   = 4'h3;

  // Fixed converter clock rates from 50 MHz system clock
  localparam int CLK_HZ   = 50_000_000;
  localparam int F4_HZ    = 4_000_000;
  localparam int F8_HZ    = 8_000_000;
  localparam int DIV4_CNT = CLK_HZ / F4_HZ;
  localparam int DIV8_CNT = CLK_HZ / F8_HZ;

  // Radio power cap in static bypass, dBm
  localparam logic [7:0] TX_CAP_DBM = 8'h0e;

  typedef enum logic [1:0] {
    SMPSC_BP_NONE,
    SMPSC_BP_STATIC,
    SMPSC_BP_DYNAMIC
  } smpsc_bypass_t;

endpackage

// File: rtl/smpsc_clkdiv.sv
`timescale 1ns/1ps
module smpsc_clkdiv #(
  parameter int W = 5
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         run,
  input  wire logic [W-1:0] ratio,
  output logic              clk_out,
  output logic              tick
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] ratio_r;
  logic [W-1:0] half;
  logic         wrap;

  assign half = ratio_r >> 1;
  assign wrap = (cnt_r >= ratio_r - 1'b1);
  assign tick = run && wrap;

  // Ratio is taken at a period boundary, and on every cycle while run is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r   <= '0;
      ratio_r <= W'(smpsc_pkg::DIV_RST);
      clk_out <= 1'b0;
    end else if (!run) begin
      cnt_r   <= '0;
      ratio_r <= ratio;
      clk_out <= 1'b0;
    end else if (wrap) begin
      cnt_r   <= '0;
      ratio_r <= ratio;
      clk_out <= 1'b1;
    end else begin
      cnt_r   <= cnt_r + 1'b1;
      clk_out <= (cnt_r + 1'b1 < half);
    end
  end

endmodule

// File: rtl/smpsc_top.sv
`timescale 1ns/1ps
module smpsc_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        no_converter,
  input  wire logic        startup_done,
  input  wire logic        stop_req,
  output logic             conv_enable,
  output logic             conv_clk,
  output logic [3:0]       conv_level,
  output logic [4:0]       conv_vout_dv,
  output logic             static_switch_on,
  output logic             bypass_reg_on,
  output logic [3:0]       bypass_reg_level,
  output logic             current_limit_on,
  output logic [7:0]       tx_power_cap,
  output logic             tx_cap_active,
  output logic             main_regulator_on,
  output logic             low_power_regulator_on,
  output logic             low_power_regulator_to_outer,
  output logic             low_power_regulator_high,
  output logic             inner_core_domain_on,
  output logic             outer_core_domain_on
);

  // Level code to output voltage in 100 mV units
  function automatic logic [4:0] level_to_dv(input logic [3:0] code);
    logic [4:0] v;
    v = 5'(code) + 5'h0a;
    if (code < smpsc_pkg::CODE_FIRST)
      v = smpsc_pkg::VOUT_MIN;
    if (v > smpsc_pkg::VOUT_MAX)
      v = smpsc_pkg::VOUT_MAX;
    return v;
  endfunction

  logic [3:0]  converter_level_code_r;
  logic        fix8_r;
  logic        variable_ratio_enable_r;
  logic [4:0]  variable_ratio_divider_r;
  logic [3:0]  converter_divider_field_r;
  logic [1:0]  bypass_req_r;
  logic        lp_high_r;
  logic        retention_high_voltage_force_r;
  logic        stop_sw_r;
  logic        static_latched_r;
  logic        started_r;
  logic [31:0] rdata_nxt;
  logic        in_stop;
  logic        dyn_bypass;
  logic        any_bypass;
  logic        conv_on;
  logic [4:0]  div_sel;
  logic [4:0]  div_clamped;
  logic        retention_voltage_status;
  logic        wr_level;
  logic        wr_clock;
  logic        wr_bypass;
  logic        wr_reg;

  assign wr_level  = wr && (addr == smpsc_pkg::OFS_LEVEL);
  assign wr_clock  = wr && (addr == smpsc_pkg::OFS_CLOCK);
  assign wr_bypass = wr && (addr == smpsc_pkg::OFS_BYPASS);
  assign wr_reg    = wr && (addr == smpsc_pkg::OFS_REG);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      converter_level_code_r         <= smpsc_pkg::LEVEL_RST;
      fix8_r                         <= 1'b0;
      variable_ratio_enable_r        <= 1'b0;
      variable_ratio_divider_r       <= smpsc_pkg::DIV_RST;
      converter_divider_field_r      <= 4'h0;
      bypass_req_r                   <= 2'h0;
      lp_high_r                      <= 1'b0;
      retention_high_voltage_force_r <= 1'b0;
      stop_sw_r                      <= 1'b0;
    end else begin
      if (wr_level)
        converter_level_code_r <= wdata[3:0];
      if (wr_clock) begin
        fix8_r                    <= wdata[smpsc_pkg::CLK_FIX8_BIT];
        variable_ratio_enable_r   <= wdata[smpsc_pkg::CLK_VAR_EN_BIT];
        variable_ratio_divider_r  <= wdata[smpsc_pkg::CLK_DIV_LSB +: 5];
        converter_divider_field_r <= wdata[smpsc_pkg::CLK_CDF_LSB +: 4];
      end
      if (wr_bypass)
        bypass_req_r <= wdata[1:0];
      if (wr_reg) begin
        lp_high_r                      <= wdata[smpsc_pkg::REG_LP_HI_BIT];
        retention_high_voltage_force_r <= wdata[smpsc_pkg::REG_FORCE_BIT];
        stop_sw_r                      <= wdata[smpsc_pkg::REG_STOP_BIT];
      end
    end
  end

  // Static bypass engages after start-up, cleared only by reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      started_r        <= 1'b0;
      static_latched_r <= 1'b0;
    end else begin
      if (startup_done)
        started_r <= 1'b1;
      if (started_r && bypass_req_r == 2'h1)
        static_latched_r <= 1'b1;
    end
  end

  assign dyn_bypass = !static_latched_r && (bypass_req_r == 2'h2);
  assign any_bypass = static_latched_r || dyn_bypass;
  assign in_stop    = stop_req || stop_sw_r;

  assign conv_on     = !no_converter && !any_bypass && !in_stop;
  assign conv_enable = conv_on;
  assign current_limit_on = any_bypass;
  assign static_switch_on = static_latched_r;
  assign bypass_reg_on    = dyn_bypass;
  assign bypass_reg_level = converter_level_code_r;
  assign conv_level       = converter_level_code_r;
  assign conv_vout_dv     = level_to_dv(converter_level_code_r);
  assign tx_cap_active    = static_latched_r;
  assign tx_power_cap     = smpsc_pkg::TX_CAP_DBM;

  // Fixed 8 MHz or 4 MHz, or variable ratio clamped to 8..16
  assign div_clamped =
    (variable_ratio_divider_r < smpsc_pkg::DIV_MIN) ? smpsc_pkg::DIV_MIN :
    (variable_ratio_divider_r > smpsc_pkg::DIV_MAX) ? smpsc_pkg::DIV_MAX :
    variable_ratio_divider_r;
  assign div_sel = variable_ratio_enable_r ? div_clamped :
                   fix8_r ? 5'(smpsc_pkg::DIV8_CNT) :
                   5'(smpsc_pkg::DIV4_CNT);

  smpsc_clkdiv #(
    .W (5)
  ) u_div (
    .clk     (clk),
    .rst     (rst),
    .run     (conv_on),
    .ratio   (div_sel),
    .clk_out (conv_clk),
    .tick    ()
  );

  assign main_regulator_on      = !in_stop;
  assign inner_core_domain_on   = !in_stop;
  assign outer_core_domain_on   = 1'b1;
  assign low_power_regulator_on = 1'b1;
  assign low_power_regulator_to_outer = in_stop;
  assign low_power_regulator_high =
    in_stop ? retention_high_voltage_force_r : lp_high_r;
  assign retention_voltage_status =
    in_stop && retention_high_voltage_force_r;

  always_comb begin
    rdata_nxt = 32'h0;
    case (addr)
      smpsc_pkg::OFS_LEVEL:  rdata_nxt[3:0] = converter_level_code_r;
      smpsc_pkg::OFS_CLOCK: begin
        rdata_nxt[smpsc_pkg::CLK_FIX8_BIT]   = fix8_r;
        rdata_nxt[smpsc_pkg::CLK_VAR_EN_BIT] = variable_ratio_enable_r;
        rdata_nxt[smpsc_pkg::CLK_DIV_LSB +: 5] = variable_ratio_divider_r;
        rdata_nxt[smpsc_pkg::CLK_CDF_LSB +: 4] = converter_divider_field_r;
      end
      smpsc_pkg::OFS_BYPASS: rdata_nxt[1:0] = bypass_req_r;
      smpsc_pkg::OFS_REG: begin
        rdata_nxt[smpsc_pkg::REG_LP_HI_BIT] = lp_high_r;
        rdata_nxt[smpsc_pkg::REG_FORCE_BIT] = retention_high_voltage_force_r;
        rdata_nxt[smpsc_pkg::REG_STOP_BIT]  = stop_sw_r;
      end
      smpsc_pkg::OFS_STATUS: begin
        rdata_nxt[0] = retention_voltage_status;
        rdata_nxt[1] = static_latched_r;
        rdata_nxt[2] = dyn_bypass;
        rdata_nxt[3] = conv_on;
        rdata_nxt[4] = in_stop;
      end
      smpsc_pkg::OFS_VOUT: rdata_nxt[4:0] = conv_vout_dv;
      default: rdata_nxt = 32'h0;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      rdata <= 32'h0;
    else if (rd)
      rdata <= rdata_nxt;
    else
      rdata <= 32'h0;
  end

endmodule

// File: tb/smpsc_sva.sv
`timescale 1ns/1ps
module smpsc_sva (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       stop_req,
  input wire logic       conv_enable,
  input wire logic       conv_clk,
  input wire logic [3:0] conv_level,
  input wire logic [4:0] conv_vout_dv,
  input wire logic       static_switch_on,
  input wire logic       bypass_reg_on,
  input wire logic [3:0] bypass_reg_level,
  input wire logic       current_limit_on,
  input wire logic [7:0] tx_power_cap,
  input wire logic       tx_cap_active,
  input wire logic       main_regulator_on,
  input wire logic       inner_core_domain_on,
  input wire logic       low_power_regulator_on,
  input wire logic       low_power_regulator_to_outer
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  vout_map_a: assert property (conv_vout_dv == (conv_level < 4'h3 ? 5'h0c :
    conv_level > 4'hd ? 5'h18 : {1'b0, conv_level} + 5'h0a))
    else $error("converter output level mismatch");
  bypass_off_a: assert property ((static_switch_on || bypass_reg_on) |->
    !conv_enable && current_limit_on)
    else $error("converter running during bypass");
  static_hold_a: assert property (static_switch_on |=> static_switch_on)
    else $error("static bypass released without reset");
  tx_cap_a: assert property (static_switch_on |-> tx_cap_active &&
    tx_power_cap == 8'h0e)
    else $error("transmit cap missing in static bypass");
  clk_idle_a: assert property (!conv_enable [*2] |-> !conv_clk)
    else $error("converter clock running while off");
  dyn_level_a: assert property (bypass_reg_on |->
    bypass_reg_level == conv_level)
    else $error("bypass regulator level differs");
  stop_regs_a: assert property (stop_req |-> !main_regulator_on &&
    !inner_core_domain_on && low_power_regulator_to_outer)
    else $error("regulator state wrong in deep stop");
  lp_always_a: assert property (low_power_regulator_on)
    else $error("low power regulator off");
  clk_period_a: assert property ($rose(conv_clk) |=>
    (!$rose(conv_clk)) [*5])
    else $error("converter clock period too short");
  clk_pulse_a: assert property ($rose(conv_clk) |->
    (conv_clk || !conv_enable) [*3])
    else $error("shortened converter clock pulse");

  cover property (static_switch_on);
  cover property (bypass_reg_on);
  cover property (stop_req && low_power_regulator_to_outer);
endmodule

// File: tb/smpsc_top_tb.sv
`timescale 1ns/1ps
module smpsc_top_tb;
  logic clk, rst, wr, rd, no_converter, startup_done, stop_req;
  logic [3:0] addr, conv_level, bypass_reg_level;
  logic [31:0] wdata, rdata, v, d, c;
  logic [4:0] conv_vout_dv;
  logic [7:0] tx_power_cap;
  logic conv_enable, conv_clk, static_switch_on, bypass_reg_on;
  logic current_limit_on, tx_cap_active, main_regulator_on;
  logic low_power_regulator_on, low_power_regulator_to_outer;
  logic low_power_regulator_high, inner_core_domain_on;
  logic outer_core_domain_on;
  int failures, checks_done, i;

  smpsc_top i_smpsc_top (.*);

  always #10 clk = ~clk;

  task summarize;
    if (failures == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  task wr_reg(input logic [3:0] a, input logic [31:0] x);
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task rd_reg(input logic [3:0] a, output logic [31:0] x);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 x = rdata;
  endtask

  // Cycles between second and third rising edge of the converter clock
  task per(output logic [31:0] n);
    int k, r;
    logic p;
    n = 0;
    r = 0;
    p = conv_clk;
    for (k = 0; k < 200 && r < 3; k++) begin
      @(posedge clk);
      #1;
      if (r > 0) n++;
      if (conv_clk === 1'b1 && p === 1'b0) begin
        r++;
        if (r < 3) n = 0;
      end
      p = conv_clk;
    end
    if (r < 3) begin
      failures++;
      summarize;
    end
  endtask

  function logic [31:0] vexp(input logic [31:0] x);
    return x < 3 ? 32'h0c : x > 13 ? 32'h18 : x + 10;
  endfunction

  initial begin
    clk = 0; rst = 1; addr = 0; wdata = 0; wr = 0; rd = 0;
    no_converter = 0; startup_done = 0; stop_req = 0;
    failures = 0; checks_done = 0;
    v = $urandom(53);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_reg(smpsc_pkg::OFS_LEVEL, v);
    chk(v, 0);
    chk({static_switch_on, bypass_reg_on, conv_enable}, 3'h1);
    rd_reg(4'hf, v);
    chk(v, 0);
    for (i = 0; i < 24; i++) begin
      c = i < 16 ? i : $urandom % 16;
      wr_reg(smpsc_pkg::OFS_LEVEL, c);
      chk(conv_vout_dv, vexp(c));
    end
    per(v);
    chk(v, 12);
    wr_reg(smpsc_pkg::OFS_CLOCK, 32'h1);
    per(v);
    chk(v, 6);
    for (i = 0; i < 6; i++) begin
      d = i < 2 ? 8 + 8 * i : 8 + $urandom % 9;
      wr_reg(smpsc_pkg::OFS_CLOCK, (d << 4) | 32'h2);
      per(v);
      chk(v, d);
    end
    wr_reg(smpsc_pkg::OFS_BYPASS, 32'h2);
    chk({conv_enable, bypass_reg_on, current_limit_on}, 3'h3);
    chk(bypass_reg_level, c[3:0]);
    repeat (20) @(posedge clk);
    #1 chk(conv_clk, 0);
    wr_reg(smpsc_pkg::OFS_BYPASS, 32'h0);
    chk(conv_enable, 1);
    wr_reg(smpsc_pkg::OFS_BYPASS, 32'h1);
    repeat (3) @(posedge clk);
    #1 chk(static_switch_on, 0);
    @(posedge clk);
    startup_done <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({static_switch_on, tx_cap_active, conv_enable}, 3'h6);
    chk(tx_power_cap, 8'h0e);
    wr_reg(smpsc_pkg::OFS_BYPASS, 32'h2);
    wr_reg(smpsc_pkg::OFS_BYPASS, 32'h0);
    chk(static_switch_on, 1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    no_converter <= 1'b1;
    @(posedge clk);
    #1 chk({static_switch_on, conv_enable}, 2'h0);
    @(posedge clk);
    no_converter <= 1'b0;
    wr_reg(smpsc_pkg::OFS_REG, 32'h1);
    chk(low_power_regulator_high, 1);
    wr_reg(smpsc_pkg::OFS_CLOCK, 32'h0);
    chk(low_power_regulator_high, 1);
    wr_reg(smpsc_pkg::OFS_REG, 32'h0);
    chk(low_power_regulator_high, 0);
    chk({main_regulator_on, inner_core_domain_on, low_power_regulator_on,
      low_power_regulator_to_outer}, 4'he);
    @(posedge clk);
    stop_req <= 1'b1;
    @(posedge clk);
    #1 chk({main_regulator_on, inner_core_domain_on, low_power_regulator_on,
      low_power_regulator_to_outer, outer_core_domain_on}, 5'h07);
    chk(low_power_regulator_high, 0);
    wr_reg(smpsc_pkg::OFS_REG, 32'h2);
    chk(low_power_regulator_high, 1);
    rd_reg(smpsc_pkg::OFS_STATUS, v);
    chk(v[0], 1);
    summarize;
  end
endmodule

bind smpsc_top smpsc_sva i_smpsc_sva (.*);
